// file: rtl/cfbr_map.svh
// Purpose: offsets, field positions and reset values of the filter routing block
// Assumes: plain register port, 16-bit registers, word index addressing
// Notes:   definitions only
`ifndef CFBR_MAP_SVH
`define CFBR_MAP_SVH
`define CFBR_ADDR_W         4
`define CFBR_OFS_PTR_4_7    4'h0
`define CFBR_OFS_PTR_8_11   4'h1
`define CFBR_OFS_STATUS     4'h2
`define CFBR_OFS_ID         4'h3
`define CFBR_PTR_RESET      16'h0000
`define CFBR_FIFO_CODE      4'hF
`define CFBR_FIELD_W        4
`define CFBR_FIRST_FILTER   4'h4
`define CFBR_LAST_FILTER    4'hB
`define CFBR_ID_VALUE       16'h5A01
`endif

// file: rtl/cfbr_pkg.sv
// Purpose: types of the filter routing block
// Assumes: cfbr_map.svh holds the numbers
// Notes:   none
package cfbr_pkg;
    typedef struct packed {
        logic [3:0]  filter;
        logic [31:0] payload;
    } cfbr_hit_t;
    typedef struct packed {
        logic        to_fifo;
        logic [3:0]  buffer;
        logic [3:0]  filter;
        logic [31:0] payload;
    } cfbr_route_t;
endpackage : cfbr_pkg

// file: rtl/cfbr_router.sv
// Purpose: steer accepted CAN messages of filters 4..11 to a buffer or the FIFO
// Assumes: hit stream and destination stream run on CLK, registers over a plain port
// Notes on behaviour
// - pointer code all ones sends the filter's messages to the receive FIFO
// - codes zero to fourteen select the receive buffer of that index
// - filter 11 destination taken from bits 15..12 of the 8-11 register
// - filter 10 destination taken from bits 11..8 of the 8-11 register
// - filter 9 destination taken from bits 7..4 of the 8-11 register
// - filter 8 destination taken from bits 3..0 of the 8-11 register
// - filter 5 destination taken from bits 7..4 of the 4-7 register
// - filter 4 destination taken from bits 3..0 of the 4-7 register
`timescale 1ns/100ps
`include "cfbr_map.svh"
module cfbr_router #(
    parameter int PAYLOAD_W = 32
) (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    // register port
    input  wire logic [`CFBR_ADDR_W-1:0] REG_ADDR,
    input  wire logic [15:0]             REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [15:0]             REG_RDATA,
    // accepted messages from the filter match logic
    input  wire cfbr_pkg::cfbr_hit_t     HIT,
    input  wire logic                    HIT_VALID,
    output logic                         HIT_READY,
    // routed messages to receive storage
    output cfbr_pkg::cfbr_route_t        ROUTE,
    output logic                         ROUTE_VALID,
    input  wire logic                    ROUTE_READY
);
    logic [15:0]           filter4_7_buffer_pointer;
    logic [15:0]           filter8_11_buffer_pointer;
    logic [3:0]            filter_four_destination;
    logic [3:0]            filter_five_destination;
    logic [3:0]            filter_six_destination;
    logic [3:0]            filter_seven_destination;
    logic [3:0]            filter_eight_destination;
    logic [3:0]            filter_nine_destination;
    logic [3:0]            filter_ten_destination;
    logic [3:0]            filter_eleven_destination;
    logic [3:0]            code;
    logic                  in_range;
    logic [7:0]            dropped;
    cfbr_pkg::cfbr_route_t next_route;
    cfbr_pkg::cfbr_route_t buf_q [2];
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [1:0]            count;
    logic                  push;
    logic                  pop;

    // field slicing
    assign filter_four_destination   = filter4_7_buffer_pointer[3:0];
    assign filter_five_destination   = filter4_7_buffer_pointer[7:4];
    assign filter_six_destination    = filter4_7_buffer_pointer[11:8];
    assign filter_seven_destination  = filter4_7_buffer_pointer[15:12];
    assign filter_eight_destination  = filter8_11_buffer_pointer[3:0];
    assign filter_nine_destination   = filter8_11_buffer_pointer[7:4];
    assign filter_ten_destination    = filter8_11_buffer_pointer[11:8];
    assign filter_eleven_destination = filter8_11_buffer_pointer[15:12];

    // register writes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            filter4_7_buffer_pointer  <= `CFBR_PTR_RESET;
            filter8_11_buffer_pointer <= `CFBR_PTR_RESET;
        end else if (REG_WR) begin
            if (REG_ADDR == `CFBR_OFS_PTR_4_7) begin
                filter4_7_buffer_pointer <= REG_WDATA;
            end else if (REG_ADDR == `CFBR_OFS_PTR_8_11) begin
                filter8_11_buffer_pointer <= REG_WDATA;
            end
        end
    end

    // register reads, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            if (REG_ADDR == `CFBR_OFS_PTR_4_7) begin
                REG_RDATA <= filter4_7_buffer_pointer;
            end else if (REG_ADDR == `CFBR_OFS_PTR_8_11) begin
                REG_RDATA <= filter8_11_buffer_pointer;
            end else if (REG_ADDR == `CFBR_OFS_STATUS) begin
                REG_RDATA <= {6'h00, count, dropped};
            end else if (REG_ADDR == `CFBR_OFS_ID) begin
                REG_RDATA <= `CFBR_ID_VALUE;   // arbitrary value
            end else begin
                REG_RDATA <= 16'h0000;
            end
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

    // destination lookup; filters outside 4..11 are not ours and are dropped
    always_comb begin
        code     = 4'h0;
        in_range = 1'b1;
        case (HIT.filter)
            4'h4:    code = filter_four_destination;
            4'h5:    code = filter_five_destination;
            4'h6:    code = filter_six_destination;
            4'h7:    code = filter_seven_destination;
            4'h8:    code = filter_eight_destination;
            4'h9:    code = filter_nine_destination;
            4'hA:    code = filter_ten_destination;
            4'hB:    code = filter_eleven_destination;
            default: in_range = 1'b0;
        endcase
        next_route.to_fifo = (code == `CFBR_FIFO_CODE);
        next_route.buffer  = next_route.to_fifo ? 4'h0 : code;
        next_route.filter  = HIT.filter;
        next_route.payload = HIT.payload;
    end

    // two-entry buffer; a receiver stall backs up to the filter logic
    assign HIT_READY   = (count != 2'h2);
    assign push        = HIT_VALID && HIT_READY && in_range;
    assign pop         = ROUTE_VALID && ROUTE_READY;
    assign ROUTE_VALID = (count != 2'h0);
    assign ROUTE       = buf_q[rd_ptr];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else if (push) begin
            buf_q[wr_ptr] <= next_route;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // count of hits naming a filter outside 4..11, saturating
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dropped <= 8'h00;
        end else if (HIT_VALID && HIT_READY && !in_range && dropped != 8'hFF) begin
            dropped <= dropped + 8'h01;
        end
    end

    sequence s_push_fifo;
        push && (code == `CFBR_FIFO_CODE) && (count == 2'h0);
    endsequence

    sequence s_push_buffer;
        push && (code != `CFBR_FIFO_CODE) && (count == 2'h0);
    endsequence

    sequence s_take_empty;
        push && !pop && (count == 2'h0);
    endsequence

    sequence s_take_second;
        push && !pop;
    endsequence

    sequence s_wr_ptr811;
        REG_WR && (REG_ADDR == `CFBR_OFS_PTR_8_11);
    endsequence

    sequence s_rd_ptr811;
        REG_RD && (REG_ADDR == `CFBR_OFS_PTR_8_11) && !REG_WR;
    endsequence

    sequence s_drop;
        HIT_VALID && HIT_READY && !in_range;
    endsequence

    sequence s_stall;
        ROUTE_VALID && !ROUTE_READY;
    endsequence

    sequence s_last_pop;
        pop && !push && (count == 2'h1);
    endsequence

    sequence s_full_pop;
        pop && !push && (count == 2'h2);
    endsequence

    a_fifo_route: assert property (@(posedge CLK) disable iff (!RST_N)
        s_push_fifo
        |=> ROUTE_VALID && ROUTE.to_fifo)
        else $error("all-ones code did not route to fifo");

    a_buffer_route: assert property (@(posedge CLK) disable iff (!RST_N)
        s_push_buffer
        |=> ROUTE_VALID && !ROUTE.to_fifo && ROUTE.buffer == $past(code))
        else $error("buffer index differs from pointer code");

    a_fifo_buffer_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        ROUTE_VALID && ROUTE.to_fifo
        |-> ROUTE.buffer == 4'h0)
        else $error("fifo route carries a buffer index");

    a_buffer_index: assert property (@(posedge CLK) disable iff (!RST_N)
        ROUTE_VALID && !ROUTE.to_fifo
        |-> ROUTE.buffer != `CFBR_FIFO_CODE)
        else $error("buffer route carries the fifo code");

    a_filter11_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'hB
        |-> code == filter8_11_buffer_pointer[15:12])
        else $error("filter 11 field wrong");

    a_filter10_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'hA
        |-> code == filter8_11_buffer_pointer[11:8])
        else $error("filter 10 field wrong");

    a_filter9_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h9
        |-> code == filter8_11_buffer_pointer[7:4])
        else $error("filter 9 field wrong");

    a_filter8_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h8
        |-> code == filter8_11_buffer_pointer[3:0])
        else $error("filter 8 field wrong");

    a_filter7_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h7
        |-> code == filter4_7_buffer_pointer[15:12])
        else $error("filter 7 field wrong");

    a_filter6_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h6
        |-> code == filter4_7_buffer_pointer[11:8])
        else $error("filter 6 field wrong");

    a_filter5_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h5
        |-> code == filter4_7_buffer_pointer[7:4])
        else $error("filter 5 field wrong");

    a_filter4_field: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT.filter == 4'h4
        |-> code == filter4_7_buffer_pointer[3:0])
        else $error("filter 4 field wrong");

    a_eleven_to_fifo: assert property (@(posedge CLK) disable iff (!RST_N)
        push && HIT.filter == 4'hB && filter8_11_buffer_pointer[15:12] == `CFBR_FIFO_CODE
        |-> next_route.to_fifo && next_route.filter == 4'hB)
        else $error("filter 11 all-ones code not sent to fifo");

    a_reg_readback: assert property (@(posedge CLK) disable iff (!RST_N)
        s_wr_ptr811 ##1 s_rd_ptr811
        |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("pointer register readback mismatch");

    a_reset_clear: assert property (@(posedge CLK)
        !RST_N
        |=> filter4_7_buffer_pointer == 16'h0000 && filter8_11_buffer_pointer == 16'h0000)
        else $error("pointer registers not cleared by reset");

    a_write_low: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `CFBR_OFS_PTR_4_7
        |=> filter4_7_buffer_pointer == $past(REG_WDATA))
        else $error("filters 4-7 pointer write lost");

    a_write_high: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR == `CFBR_OFS_PTR_8_11
        |=> filter8_11_buffer_pointer == $past(REG_WDATA))
        else $error("filters 8-11 pointer write lost");

    a_pointer_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        !REG_WR
        |=> $stable(filter4_7_buffer_pointer) && $stable(filter8_11_buffer_pointer))
        else $error("pointer changed without a write");

    a_other_write: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_WR && REG_ADDR != `CFBR_OFS_PTR_4_7 && REG_ADDR != `CFBR_OFS_PTR_8_11
        |=> $stable(filter4_7_buffer_pointer) && $stable(filter8_11_buffer_pointer))
        else $error("unmapped write changed a pointer");

    a_read_low: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == `CFBR_OFS_PTR_4_7
        |=> REG_RDATA == $past(filter4_7_buffer_pointer))
        else $error("filters 4-7 pointer read wrong");

    a_read_high: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == `CFBR_OFS_PTR_8_11
        |=> REG_RDATA == $past(filter8_11_buffer_pointer))
        else $error("filters 8-11 pointer read wrong");

    a_read_status: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == `CFBR_OFS_STATUS
        |=> REG_RDATA == {6'h00, $past(count), $past(dropped)})
        else $error("status read wrong");

    a_read_ident: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == `CFBR_OFS_ID
        |=> REG_RDATA == `CFBR_ID_VALUE)
        else $error("identity read wrong");

    a_rdata_idle: assert property (@(posedge CLK) disable iff (!RST_N)
        !REG_RD
        |=> REG_RDATA == 16'h0000)
        else $error("read data not zero outside a read");

    a_back_order: assert property (@(posedge CLK) disable iff (!RST_N)
        s_take_empty ##1 s_take_second
        |=> ROUTE == $past(next_route, 2))
        else $error("routed messages out of order");

    a_stall_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        s_stall
        |=> ROUTE_VALID && $stable(ROUTE))
        else $error("route changed during a stall");

    a_full_refuse: assert property (@(posedge CLK) disable iff (!RST_N)
        s_take_empty ##1 s_take_second
        |=> !HIT_READY)
        else $error("full buffer still ready");

    a_drop_count: assert property (@(posedge CLK) disable iff (!RST_N)
        s_drop ##0 (dropped != 8'hFF)
        |=> dropped == $past(dropped) + 8'h01)
        else $error("dropped hit not counted");

    a_drop_no_route: assert property (@(posedge CLK) disable iff (!RST_N)
        s_drop ##0 (count == 2'h0)
        |=> !ROUTE_VALID)
        else $error("foreign filter hit was routed");

    a_last_pop: assert property (@(posedge CLK) disable iff (!RST_N)
        s_last_pop
        |=> !ROUTE_VALID)
        else $error("buffer not empty after last pop");

    a_full_pop: assert property (@(posedge CLK) disable iff (!RST_N)
        s_full_pop
        |=> HIT_READY && ROUTE_VALID)
        else $error("pop from full buffer mishandled");

    a_reset_outputs: assert property (@(posedge CLK)
        !RST_N
        |=> !ROUTE_VALID && HIT_READY && REG_RDATA == 16'h0000)
        else $error("outputs not idle after reset");

endmodule : cfbr_router

// file: testbench/cfbr_hit_src.sv
// Purpose: accepted-message source standing in for the filter match logic
// Assumes: bench pushes hits into q, one per word
// Notes:   idle bus inverts its value each cycle, so every second idle cycle shows the last value again
`timescale 1ns/100ps
module cfbr_hit_src (
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          RST_N,
    // hit stream
    input  wire logic          HIT_READY,
    output cfbr_pkg::cfbr_hit_t HIT,
    output logic               HIT_VALID
);
    cfbr_pkg::cfbr_hit_t q[$];
    initial begin
        HIT = '1;
        HIT_VALID = 1'b0;
    end
    // request held until taken at a ready edge
    always @(posedge CLK) begin
        if (RST_N && HIT_VALID && HIT_READY) void'(q.pop_front());
        if (RST_N && q.size() != 0) begin
            HIT       <= q[0];
            HIT_VALID <= 1'b1;
        end else begin
            HIT       <= ~HIT;
            HIT_VALID <= 1'b0;
        end
    end
endmodule : cfbr_hit_src

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the filter routing block
// Assumes: hit source model in cfbr_hit_src.sv
// Notes:   bench is the receive storage; it stalls to fill the buffer
`timescale 1ns/100ps
`include "cfbr_map.svh"
module tb_top;
    logic                  CLK, RST_N, REG_WR, REG_RD, HIT_VALID, HIT_READY;
    logic                  ROUTE_VALID, ROUTE_READY;
    logic [3:0]            REG_ADDR;
    logic [15:0]           REG_WDATA, REG_RDATA, lo, hi;
    cfbr_pkg::cfbr_hit_t   HIT;
    cfbr_pkg::cfbr_route_t ROUTE, exp_q[$];
    int                    failures = 0;
    int                    n_checks = 0;
    cfbr_router uut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .HIT(HIT),
        .HIT_VALID(HIT_VALID), .HIT_READY(HIT_READY), .ROUTE(ROUTE),
        .ROUTE_VALID(ROUTE_VALID), .ROUTE_READY(ROUTE_READY));
    cfbr_hit_src src (.CLK(CLK), .RST_N(RST_N), .HIT_READY(HIT_READY), .HIT(HIT),
        .HIT_VALID(HIT_VALID));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    task automatic check(input logic [40:0] got, input logic [40:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // strobes are left up so the next call can follow with no gap; idle drops them
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        REG_RD    <= 1'b0;
        @(posedge CLK);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        REG_WR   <= 1'b0;
        @(posedge CLK);
        #1 check(41'(REG_RDATA), 41'(e));
    endtask : rd
    task automatic idle();
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        @(posedge CLK);
    endtask : idle
    // expectation uses the pointer copy the bench last wrote
    task automatic hit(input logic [3:0] f, input logic [31:0] p);
        logic [3:0] code;
        code = (f < 4'h8) ? lo[4*(f%4) +: 4] : hi[4*(f%4) +: 4];
        src.q.push_back({f, p});
        if (f >= `CFBR_FIRST_FILTER && f <= `CFBR_LAST_FILTER)
            exp_q.push_back({code == `CFBR_FIFO_CODE, (code == 4'hF) ? 4'h0 : code, f, p});
    endtask : hit
    task automatic drain();
        for (int i = 0; i < 60 && (src.q.size() != 0 || exp_q.size() != 0); i++) @(posedge CLK);
        check(41'(exp_q.size()), 41'h0);
    endtask : drain
    always @(posedge CLK) begin
        if (RST_N && ROUTE_VALID && ROUTE_READY) begin
            if (exp_q.size() == 0) check(ROUTE, ~ROUTE);
            else check(ROUTE, exp_q.pop_front());
        end
    end
    initial begin
        #(100 * 6000);
        failures++;
        print_verdict();
    end
    initial begin
        {REG_ADDR, REG_WDATA, REG_WR, REG_RD, RST_N, lo, hi} = '0;
        ROUTE_READY = 1'b1;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rd(`CFBR_OFS_PTR_4_7, `CFBR_PTR_RESET);
        rd(`CFBR_OFS_PTR_8_11, `CFBR_PTR_RESET);
        idle();
        hit(4'h7, 32'h0000_0007);
        drain();
        // every code reaches every filter, fields all differ per pass
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 4; k++) begin
                lo[4*k +: 4] = 4'(c + k);
                hi[4*k +: 4] = 4'(c + k + 4);
            end
            wr(`CFBR_OFS_PTR_4_7, lo);
            wr(`CFBR_OFS_PTR_8_11, hi);
            rd(`CFBR_OFS_PTR_8_11, hi);
            rd(`CFBR_OFS_PTR_4_7, lo);
            idle();
            ROUTE_READY <= 1'b0;
            for (int f = 4; f < 12; f++) hit(4'(f), {8'(c), 20'h0, 4'(f)});
            repeat (4) @(posedge CLK);
            #1 check(41'({HIT_READY, ROUTE_VALID}), 41'h1);
            ROUTE_READY <= 1'b1;
            drain();
        end
        hit(4'h2, 32'h0000_0002);
        hit(4'hC, 32'h0000_000C);
        drain();
        rd(`CFBR_OFS_STATUS, 16'h0002);
        wr(`CFBR_OFS_ID, 16'h0000);
        rd(`CFBR_OFS_ID, `CFBR_ID_VALUE);
        rd(4'hF, 16'h0000);
        idle();
        print_verdict();
    end
endmodule : tb_top
